// ===== rtl/train_irq_pkg.sv
// Notes on behaviour
// - Pulse-train mode with software select set: start train only on software trigger.
// - Pulse-train mode with software select clear: start train only on pin transition.
// - Software-trigger select is ignored outside pulse-train mode.
// - Writing one to trigger flag with software select set begins a train.
// - Second counter underflow clears the trigger flag, ending the train.
// - Pin-triggered pulse-train mode blocks software writes to the trigger flag.
// - Pin-started train holds the trigger flag at one until the train completes.
// - Train mode select only counts when timer mode select equals 00b.
// - Pending flags A to D are read-only bits 0 to 3 of control register.
// - Enable bits A to D are read-write bits 4 to 7 of control register.
// - Writing one to clear register bit n clears pending flag n.
// - Global enable low holds pending cleared, resets prescaler, blocks pending writes.
`default_nettype none

package train_irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_SRC = 4;
	localparam int PRESC_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_TRAIN_MODE = 8;
	localparam int BIT_SW_SEL = 9;
	localparam int BIT_TRIG = 10;
	localparam int BIT_EN_LO = 4;
	localparam logic [1:0] MODE_PWM = 2'h0;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;
endpackage : train_irq_pkg

`default_nettype wire

// ===== rtl/timer_pulse_train_irq_ctrl.sv
// Local design decision: strobed register access.
`default_nettype none

module timer_pulse_train_irq_ctrl
	import train_irq_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [DATA_W-1:0] RDATA_O,
	// Timer side
	input wire logic SECOND_COUNTER_UNDERFLOW_I,
	input wire logic EXT_TRIGGER_PIN_I,
	input wire logic [NUM_SRC-1:0] IRQ_EVENT_I,
	output logic TRAIN_START_O,
	output logic TRAIN_ACTIVE_O,
	output logic [PRESC_W-1:0] PRESCALER_O,
	output logic IRQ_O
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		hit = (a == o);
	endfunction : hit

	logic [1:0] mode_q;
	logic global_en_q;
	logic train_mode_q;
	logic sw_sel_q;
	logic trig_q;
	logic [NUM_SRC-1:0] pend_q;
	logic [NUM_SRC-1:0] en_q;
	logic [PRESC_W-1:0] presc_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic [1:0] pin_arm_q;
	logic start_q;
	logic irq_q;
	logic [DATA_W-1:0] rdata_q;

	wire wr_ctrl = WR_I && hit(ADDR_I, OFS_CTRL);
	wire wr_ictrl = WR_I && hit(ADDR_I, OFS_IRQ_CTRL);
	wire wr_iclr = WR_I && hit(ADDR_I, OFS_IRQ_CLR);
	wire [NUM_SRC-1:0] en_wdata = WDATA_I[BIT_EN_LO +: NUM_SRC];

	// ----------------------------------------
	// Trigger flag
	// ----------------------------------------
	// Train mode only counts in the PWM mode-select value
	wire train_mode = train_mode_q && (mode_q == MODE_PWM);
	// Select bit is qualified by train mode so it is inert elsewhere
	wire sw_sel_eff = train_mode && sw_sel_q;
	// Edges are ignored until the synchroniser has refilled after reset
	wire pin_edge = pin_arm_q[1] && (pin_s2_q ^ pin_s3_q);
	wire sw_start = wr_ctrl && sw_sel_eff && WDATA_I[BIT_TRIG] && !trig_q;
	wire pin_start = train_mode && !sw_sel_q && pin_edge && !trig_q;
	// A start needs the global enable; a start while the flag is set is ignored
	wire start = global_en_q && (sw_start || pin_start);
	// Writes to the flag are only honoured outside pin-triggered train mode
	wire trig_wr_ok = !(train_mode && !sw_sel_q);

	// Underflow comes last so it wins over a start in the same cycle
	logic trig_d;
	always_comb begin
		trig_d = trig_q;
		if (wr_ctrl && trig_wr_ok) begin
			trig_d = WDATA_I[BIT_TRIG];
		end
		if (start) begin
			trig_d = 1'b1;
		end
		if (SECOND_COUNTER_UNDERFLOW_I) begin
			trig_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Set wins over clear so an event in the clear cycle is kept
	wire [NUM_SRC-1:0] clr_mask = wr_iclr ? WDATA_I[NUM_SRC-1:0] : '0;
	wire [NUM_SRC-1:0] pend_d = global_en_q ? ((pend_q & ~clr_mask) | IRQ_EVENT_I) : '0;
	wire irq_d = |(pend_d & en_q);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [DATA_W-1:0] ctrl_word = {21'h0, trig_q, sw_sel_q, train_mode_q, global_en_q,
		5'h0, mode_q};
	wire [DATA_W-1:0] ictrl_word = {24'h0, en_q, pend_q};
	// Reads of the clear register and of unmapped offsets return zero
	wire [DATA_W-1:0] rd_mux = !RD_I ? ZERO_WORD :
		hit(ADDR_I, OFS_CTRL) ? ctrl_word :
		hit(ADDR_I, OFS_IRQ_CTRL) ? ictrl_word :
		hit(ADDR_I, OFS_STATUS) ? {31'h0, trig_q} : ZERO_WORD;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			mode_q <= 2'h0;
			global_en_q <= 1'b0;
			train_mode_q <= 1'b0;
			sw_sel_q <= 1'b0;
		end else if (wr_ctrl) begin
			mode_q <= WDATA_I[BIT_MODE_HI:BIT_MODE_LO];
			global_en_q <= WDATA_I[BIT_GLOBAL_EN];
			train_mode_q <= WDATA_I[BIT_TRAIN_MODE];
			sw_sel_q <= WDATA_I[BIT_SW_SEL];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			trig_q <= 1'b0;
			pend_q <= '0;
			en_q <= '0;
			irq_q <= 1'b0;
			start_q <= 1'b0;
			rdata_q <= ZERO_WORD;
		end else begin
			trig_q <= trig_d;
			pend_q <= pend_d;
			if (wr_ictrl) begin
				en_q <= en_wdata;
			end
			irq_q <= irq_d;
			start_q <= start;
			rdata_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// Prescaler held in reset while the timer is off to save power
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I || !global_en_q) begin
			presc_q <= PRESC_RESET;
		end else begin
			presc_q <= presc_q + 8'h01;
		end
	end

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	// No reset on the stages: they follow the pin through reset, so a pin
	// that idles high does not look like an edge once reset ends
	always_ff @(posedge CLK_I) begin
		pin_s1_q <= EXT_TRIGGER_PIN_I;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end

	// Arming covers a reset too short to have filled the stages
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			pin_arm_q <= 2'h0;
		end else begin
			pin_arm_q <= {pin_arm_q[0], 1'b1};
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign RDATA_O = rdata_q;
	assign TRAIN_START_O = start_q;
	assign TRAIN_ACTIVE_O = trig_q;
	assign PRESCALER_O = presc_q;
	assign IRQ_O = irq_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_underflow_clears;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		SECOND_COUNTER_UNDERFLOW_I |=> !TRAIN_ACTIVE_O;
	endproperty
	a_underflow_clears: assert property (p_underflow_clears) else $error("flag not cleared");

	property p_sw_start;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_ctrl && WDATA_I[BIT_TRIG] && sw_sel_eff && global_en_q && !trig_q
			&& !SECOND_COUNTER_UNDERFLOW_I) |=> (TRAIN_START_O && TRAIN_ACTIVE_O);
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start missed");

	property p_sw_only;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(sw_sel_eff && !wr_ctrl) |=> !TRAIN_START_O;
	endproperty
	a_sw_only: assert property (p_sw_only) else $error("start without software");

	property p_pin_only;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(train_mode && !sw_sel_q && !pin_edge) |=> !TRAIN_START_O;
	endproperty
	a_pin_only: assert property (p_pin_only) else $error("start without pin edge");

	property p_no_mode;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(mode_q != MODE_PWM) |=> !TRAIN_START_O;
	endproperty
	a_no_mode: assert property (p_no_mode) else $error("start outside train mode");

	property p_blocked;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_ctrl && train_mode && !sw_sel_q && !WDATA_I[BIT_TRIG] && trig_q
			&& !SECOND_COUNTER_UNDERFLOW_I) |=> TRAIN_ACTIVE_O;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked write changed flag");

	property p_disabled;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		!global_en_q |=> (pend_q == '0 && PRESCALER_O == PRESC_RESET);
	endproperty
	a_disabled: assert property (p_disabled) else $error("state kept while disabled");

	property p_clear;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_iclr && WDATA_I[0] && !IRQ_EVENT_I[0]) |=> !pend_q[0];
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	property p_irq;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		##1 (IRQ_O == |(pend_q & $past(en_q)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_pin_start;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(train_mode && !sw_sel_q && pin_edge && !trig_q && global_en_q
			&& !SECOND_COUNTER_UNDERFLOW_I) |=> (TRAIN_START_O && TRAIN_ACTIVE_O);
	endproperty
	a_pin_start: assert property (p_pin_start) else $error("pin start missed");

	property p_held_pin;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(trig_q && train_mode && !sw_sel_q && !SECOND_COUNTER_UNDERFLOW_I)
			|=> TRAIN_ACTIVE_O;
	endproperty
	a_held_pin: assert property (p_held_pin) else $error("pin train flag dropped");

	property p_sel_inert;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		!train_mode |=> !TRAIN_START_O;
	endproperty
	a_sel_inert: assert property (p_sel_inert) else $error("select not inert");

	property p_pend_ro;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_ictrl && global_en_q && IRQ_EVENT_I == '0) |=> (pend_q == $past(pend_q));
	endproperty
	a_pend_ro: assert property (p_pend_ro) else $error("pending written directly");

	property p_en_write;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_ictrl |=> (en_q == $past(en_wdata));
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable write lost");

	property p_set_wins;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_iclr && global_en_q)
			|=> ((pend_q & $past(IRQ_EVENT_I)) == $past(IRQ_EVENT_I));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

	property p_clear_zero;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		(wr_iclr && WDATA_I[NUM_SRC-1:0] == '0 && global_en_q)
			|=> ((pend_q & $past(pend_q)) == $past(pend_q));
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("zero clear acted");

	property p_read_idle;
		@(posedge CLK_I) disable iff (SYS_RST_I)
		!RD_I |=> (RDATA_O == ZERO_WORD);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

	// ----------------------------------------
	// Cover
	// ----------------------------------------
	c_sw_train: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
		sw_start ##[1:20] SECOND_COUNTER_UNDERFLOW_I);
	c_pin_train: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) pin_start);
	c_irq: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) IRQ_O ##1 wr_iclr);
	c_set_wins: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_iclr && global_en_q && |(WDATA_I[NUM_SRC-1:0] & IRQ_EVENT_I));
	c_pin_held: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_ctrl && trig_q && train_mode && !sw_sel_q);

endmodule : timer_pulse_train_irq_ctrl

`default_nettype wire

// ===== sim/timer_pulse_train_irq_ctrl_tb.sv
`default_nettype none

module timer_pulse_train_irq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import train_irq_pkg::*;

	typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} row_t;
	// Control goes last so that the timer is enabled once the table is done
	row_t rows [4] = '{'{8'h1C, 32'h0000_00FF, 32'h0000_00F0}, '{8'h20, 32'h0000_000F, 32'h0},
		'{8'h40, 32'h0000_00FF, 32'h0}, '{8'h00, 32'h0000_0083, 32'h0000_0083}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic uf = 1'b0;
	logic pin = 1'b0;
	logic [NUM_SRC-1:0] ev = '0;
	logic [DATA_W-1:0] rdata;
	logic start;
	logic active;
	logic [PRESC_W-1:0] presc;
	logic irq;
	logic got;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;

	timer_pulse_train_irq_ctrl i_timer_pulse_train_irq_ctrl (
		.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .SECOND_COUNTER_UNDERFLOW_I(uf), .EXT_TRIGGER_PIN_I(pin),
		.IRQ_EVENT_I(ev), .TRAIN_START_O(start), .TRAIN_ACTIVE_O(active),
		.PRESCALER_O(presc), .IRQ_O(irq)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			summarize();
		end
	end

	// --------------------------------------------------------------
	// Bus and stimulus tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wrt(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wrt

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e, n);
	endtask : rdc

	task automatic pls(input logic [NUM_SRC-1:0] e, input logic u);
		@(posedge clk);
		ev <= e;
		uf <= u;
		@(posedge clk);
		ev <= '0;
		uf <= 1'b0;
		#1;
	endtask : pls

	// Pin passes a synchroniser, so allow a few cycles for the start pulse
	task automatic seek();
		got = 1'b0;
		@(posedge clk);
		pin <= ~pin;
		repeat (8) begin
			@(posedge clk);
			#1;
			if (start === 1'b1) got = 1'b1;
		end
	endtask : seek

	task automatic summarize();
		$display("Checks %0d, errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(irq, 1'b0, "irq reset");
		rdc(OFS_IRQ_CTRL, ZERO_WORD, "irq ctrl reset");
		rdc(OFS_CTRL, ZERO_WORD, "ctrl reset");
		pls(4'hF, 1'b0);
		rdc(OFS_IRQ_CTRL, ZERO_WORD, "pend disabled");
		chk(presc, PRESC_RESET, "presc held");
		foreach (rows[i]) begin
			wrt(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e, "row");
		end
		chk(presc !== PRESC_RESET, 1'b1, "presc runs");
		pls(4'hF, 1'b0);
		chk(irq, 1'b1, "irq set");
		wrt(OFS_IRQ_CLR, ZERO_WORD);
		rdc(OFS_IRQ_CTRL, 32'h0000_00FF, "clear zero");
		wrt(OFS_IRQ_CLR, 32'h0000_0001);
		rdc(OFS_IRQ_CTRL, 32'h0000_00FE, "clear A");
		wrt(OFS_IRQ_CTRL, 32'h0000_0010);
		@(posedge clk);
		#1;
		chk(irq, 1'b0, "masked");
		wrt(OFS_IRQ_CTRL, 32'h0000_0021);
		@(posedge clk);
		#1;
		chk(irq, 1'b1, "B on");
		wrt(OFS_IRQ_CLR, 32'h0000_000E);
		chk(irq, 1'b0, "cleared");
		rdc(OFS_IRQ_CTRL, 32'h0000_0020, "pend read only");
		// Event and clear of the same source in one cycle: the event must stay
		@(posedge clk);
		ev <= 4'h2;
		addr <= OFS_IRQ_CLR;
		wdata <= 32'h0000_0002;
		wr <= 1'b1;
		@(posedge clk);
		ev <= '0;
		wr <= 1'b0;
		#1;
		chk(irq, 1'b1, "set wins");
		pls(4'h4, 1'b0);
		wrt(OFS_CTRL, ZERO_WORD);
		rdc(OFS_IRQ_CTRL, 32'h0000_0020, "off clears");
		wrt(OFS_CTRL, 32'h0000_0380);
		seek();
		chk(got, 1'b0, "pin in sw");
		wrt(OFS_CTRL, 32'h0000_0780);
		chk({start, active}, 2'b11, "sw start");
		rdc(OFS_STATUS, 32'h0000_0001, "status");
		pls(4'h0, 1'b1);
		chk(active, 1'b0, "uf end");
		wrt(OFS_CTRL, 32'h0000_0180);
		wrt(OFS_CTRL, 32'h0000_0580);
		chk({start, active}, 2'b00, "sw blocked");
		seek();
		chk({got, active}, 2'b11, "pin start");
		wrt(OFS_CTRL, 32'h0000_0180);
		chk(active, 1'b1, "held");
		pls(4'h0, 1'b1);
		chk(active, 1'b0, "pin end");
		wrt(OFS_CTRL, 32'h0000_0181);
		seek();
		chk(got, 1'b0, "pin mode 1");
		wrt(OFS_CTRL, 32'h0000_0781);
		chk(start, 1'b0, "sw mode 1");
		// Second reset in mid-run with the flag and enables set
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({active, irq, start}, 3'b000, "mid reset");
		rdc(OFS_CTRL, ZERO_WORD, "ctrl after reset");
		rdc(OFS_IRQ_CTRL, ZERO_WORD, "irq ctrl after reset");
		summarize();
	end
endmodule : timer_pulse_train_irq_ctrl_tb

`default_nettype wire
